// File: core/tsh_startup.sv
`timescale 1ns/1ns
`default_nettype none

module tsh_startup #(
  parameter int FLOAT_CYCLES  = tsh_pkg::FLOAT_CYC,
  parameter int CAL_CYCLES    = tsh_pkg::CAL_CYC,
  parameter int WAKE_CYCLES   = tsh_pkg::WAKE_CYC,
  parameter int SETTLE_CYCLES = tsh_pkg::SETTLE_CYC,
  parameter int SLEEP_CYCLES  = tsh_pkg::SLEEP_CYC,
  parameter int BURST_CYCLES  = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Serial pins from host
  input  wire logic             ss_n_pin,
  input  wire logic             sclk_pin,
  // Serial data out from shifter, driven out while framed in the ready state
  input  wire logic             miso_data,
  output var tsh_pkg::tsh_pin_t miso,
  // Touch state from sensing core
  input  wire logic             touched,
  output var tsh_pkg::tsh_pin_t detect,
  output var tsh_pkg::tsh_pin_t transfer_permit,
  // Burst strobe to the sensing core
  output logic                  burst_start,
  output logic                  settled_burst
);
  import tsh_pkg::*;

  // Counters are CNT_W wide; the checks below need a few cycles per phase
  if (FLOAT_CYCLES < 1 || CAL_CYCLES < 5 || WAKE_CYCLES < 4 || SETTLE_CYCLES < 9
      || SLEEP_CYCLES < 2 || BURST_CYCLES < 1
      || FLOAT_CYCLES >= (1 << CNT_W) || CAL_CYCLES >= (1 << CNT_W)
      || WAKE_CYCLES >= (1 << CNT_W) || SETTLE_CYCLES >= (1 << CNT_W)
      || BURST_CYCLES >= (1 << CNT_W)) begin : g_bad_cycles
    $error("tsh_startup: bad cycle counts");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] ss_sync_q, ss_sync_d, ck_sync_q, ck_sync_d;
  logic       ck_last_q, ck_last_d, ss_last_q, ss_last_d;
  logic       ss_n, sclk, ck_edge, ss_rise;

  always_comb begin
    ss_sync_d = {ss_sync_q[0], ss_n_pin};
    ck_sync_d = {ck_sync_q[0], sclk_pin};
    ss_n      = ss_sync_q[1];
    sclk      = ck_sync_q[1];
    ck_last_d = sclk;
    ss_last_d = ss_n;
    ck_edge   = sclk & ~ck_last_q;
    ss_rise   = ss_n & ~ss_last_q;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ss_sync_q <= 2'h3;
      ck_sync_q <= 2'h3;
      ck_last_q <= 1'h1;
      ss_last_q <= 1'h1;
    end else begin
      ss_sync_q <= ss_sync_d;
      ck_sync_q <= ck_sync_d;
      ck_last_q <= ck_last_d;
      ss_last_q <= ss_last_d;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  tsh_state_t       state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [CNT_W-1:0] idle_q, idle_d;
  logic             slept_q, slept_d;
  logic             clocked_q, clocked_d;

  always_comb begin
    state_d       = state_q;
    cnt_d         = cnt_q + 24'h000001;
    idle_d        = ck_edge ? 24'h000000 : idle_q + 24'h000001;
    slept_d       = slept_q;
    clocked_d     = clocked_q | (ck_edge & ~ss_n);
    burst_start   = 1'b0;
    settled_burst = 1'b0;
    unique case (state_q)
      TSH_FLOAT: if (cnt_q == CNT_W'(FLOAT_CYCLES - 1)) begin
        state_d = TSH_CAL;
        cnt_d   = '0;
      end
      TSH_CAL: if (cnt_q == CNT_W'(CAL_CYCLES - 1)) begin
        state_d   = TSH_READY;
        clocked_d = 1'b0;
      end
      TSH_READY: begin
        cnt_d = '0;
        if (clocked_q && idle_q >= CNT_W'(SLEEP_CYCLES - 1)) begin
          state_d = TSH_SLEEP;
        end else if (ss_rise) begin
          state_d     = TSH_BURST;
          burst_start = 1'b1;
          slept_d     = 1'b0;
        end
      end
      TSH_SLEEP: begin
        cnt_d     = '0;
        clocked_d = 1'b0;
        if (ss_rise || ck_edge) begin
          state_d = TSH_WAKE;
          slept_d = 1'b1;
        end
      end
      TSH_WAKE: if (cnt_q == CNT_W'(WAKE_CYCLES - 1)) begin
        state_d = TSH_SETTLE;
        cnt_d   = '0;
      end
      TSH_SETTLE: if (cnt_q == CNT_W'(SETTLE_CYCLES - 1)) begin
        state_d       = TSH_BURST;
        cnt_d         = '0;
        burst_start   = 1'b1;
        settled_burst = 1'b1;
      end
      TSH_BURST: if (cnt_q == CNT_W'(BURST_CYCLES - 1)) begin
        state_d   = TSH_READY;
        clocked_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q   <= TSH_FLOAT;
      cnt_q     <= '0;
      idle_q    <= '0;
      slept_q   <= 1'b0;
      clocked_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      idle_q    <= idle_d;
      slept_q   <= slept_d;
      clocked_q <= clocked_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  tsh_pin_t miso_d, miso_q, det_d, det_q, perm_d, perm_q;
  logic     floating;

  always_comb begin
    floating = (state_q == TSH_FLOAT) || (state_q == TSH_WAKE);
    perm_d.o    = (state_d == TSH_READY) && (state_q == TSH_READY || state_q == TSH_BURST
                  || state_q == TSH_CAL);
    perm_d.oe_n = (state_d == TSH_FLOAT) || (state_d == TSH_WAKE);
    det_d.o     = touched;
    det_d.oe_n  = (state_d == TSH_WAKE);
    miso_d.o    = miso_data;
    miso_d.oe_n = ss_n || (state_q != TSH_READY);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      perm_q <= '{o: 1'b0, oe_n: 1'b1};
      det_q  <= '{o: 1'b0, oe_n: 1'b0};
      miso_q <= '{o: 1'b0, oe_n: 1'b1};
    end else begin
      perm_q <= perm_d;
      det_q  <= det_d;
      miso_q <= miso_d;
    end
  end

  assign transfer_permit = perm_q;
  assign detect          = det_q;
  assign miso            = miso_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_SETTLE_GAP: assert property (@(posedge clk) disable iff (!rstn)
    $rose(state_q == TSH_SETTLE) |-> (state_q == TSH_SETTLE) [*8] ##0 !burst_start)
    else $error("burst came before settling ended");
  AST_NO_SETTLE: assert property (@(posedge clk) disable iff (!rstn)
    (state_q == TSH_READY && burst_start) |-> !settled_burst ##1 state_q == TSH_BURST)
    else $error("direct burst used settling path");
  AST_MISO_FLOAT: assert property (@(posedge clk) disable iff (!rstn)
    (state_q != TSH_READY) |=> miso.oe_n)
    else $error("serial output driven outside transfer");
  AST_PERMIT_READY: assert property (@(posedge clk) disable iff (!rstn)
    (transfer_permit.o && !transfer_permit.oe_n) |-> state_q == TSH_READY)
    else $error("permit high while busy");
  AST_FLOAT_PHASE: assert property (@(posedge clk) disable iff (!rstn)
    (state_q == TSH_FLOAT) |=> transfer_permit.oe_n || state_q == TSH_CAL)
    else $error("permit driven during power-up float");
  AST_CAL_LOW: assert property (@(posedge clk) disable iff (!rstn)
    $rose(state_q == TSH_CAL) |=> (!transfer_permit.o && !transfer_permit.oe_n) [*4])
    else $error("permit not low in calibration");
  AST_SLEEP_LOW: assert property (@(posedge clk) disable iff (!rstn)
    (state_q == TSH_READY && state_d == TSH_SLEEP) |=> ##[0:1] !transfer_permit.o)
    else $error("permit high entering sleep");
  AST_WAKE_FLOAT: assert property (@(posedge clk) disable iff (!rstn)
    $rose(state_q == TSH_WAKE) |-> ##1 (detect.oe_n && transfer_permit.oe_n) [*3])
    else $error("outputs driven during wake");

  COV_STARTUP: cover property (@(posedge clk) disable iff (!rstn)
    state_q == TSH_CAL ##1 state_q == TSH_READY);
  COV_WAKE_BURST: cover property (@(posedge clk) disable iff (!rstn) settled_burst);
  COV_DIRECT_BURST: cover property (@(posedge clk) disable iff (!rstn)
    burst_start && !settled_burst);
  COV_SLEEP: cover property (@(posedge clk) disable iff (!rstn) state_q == TSH_SLEEP);

endmodule : tsh_startup

`default_nettype wire

// File: core/tsh_pkg.sv
`default_nettype none

package tsh_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS            = 100;
  localparam int WAKE_US           = 400;
  localparam int SETTLE_US         = 500;
  localparam int SLEEP_US          = 35;
  localparam int FLOAT_MS          = 20;
  localparam int CAL_MS            = 525;
  localparam int HOST_WAIT_MS      = 550;
  localparam int WAKE_CYC          = WAKE_US * 1000 / CLK_NS;
  localparam int SETTLE_CYC        = (SETTLE_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int SLEEP_CYC         = SLEEP_US * 1000 / CLK_NS;
  localparam int FLOAT_CYC         = FLOAT_MS * 1000000 / CLK_NS;
  localparam int CAL_CYC           = CAL_MS * 1000000 / CLK_NS;
  localparam int CNT_W             = 24;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TSH_FLOAT, TSH_CAL, TSH_READY, TSH_SLEEP, TSH_WAKE, TSH_SETTLE, TSH_BURST
  } tsh_state_t;

  // Pin driver group: out value and active-low enable
  typedef struct packed {
    logic o;
    logic oe_n;
  } tsh_pin_t;

endpackage : tsh_pkg

`default_nettype wire

// File: test/tsh_host_model.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// Host bus master
// ----------------------------------------------------------------
module tsh_host_model (
  // Clock
  input  wire logic              clk,
  // Ready pin from device
  input  wire tsh_pkg::tsh_pin_t transfer_permit,
  // Dedicated select and clock to this device only
  // own select line
  output var logic               ss_n_pin,
  output var logic               sclk_pin
);
  import tsh_pkg::*;

  logic permit_lvl;

  // Board pull-down: a floating pin reads low
  assign permit_lvl = transfer_permit.oe_n ? 1'b0 : transfer_permit.o;

  initial begin
    ss_n_pin = 1'b1;
    sclk_pin = 1'b1;
  end

  // frame only once ready is seen
  task automatic frame(input int edges, input bit keep_low, output bit ok);
    int n;
    ok = 1'b0;
    for (n = 0; n < 2000 && !ok; n++) begin
      @(negedge clk);
      ok = permit_lvl;
    end
    if (ok) begin
      ss_n_pin = 1'b0;
      repeat (4) @(negedge clk);
      for (n = 0; n < edges; n++) begin
        sclk_pin = 1'b0;
        repeat (2) @(negedge clk);
        sclk_pin = 1'b1;
        repeat (2) @(negedge clk);
      end
      if (!keep_low) ss_n_pin = 1'b1;
    end
  endtask : frame

  task automatic release_ss;
    ss_n_pin = 1'b1;
  endtask : release_ss
endmodule : tsh_host_model

`default_nettype wire

// File: test/tsh_startup_tb.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// Startup and wake bench
// ----------------------------------------------------------------
module tsh_startup_tb;
  import tsh_pkg::*;

  logic     clk, rstn, miso_data, touched, burst_start, settled_burst;
  wire      ss_n_pin, sclk_pin;
  tsh_pin_t miso, detect, transfer_permit;
  int       err_total, check_count, n;
  bit       ok;

  tsh_startup #(.FLOAT_CYCLES(20), .CAL_CYCLES(50), .WAKE_CYCLES(8), .SETTLE_CYCLES(10),
    .SLEEP_CYCLES(5)) tsh_startup_inst (.clk(clk), .rstn(rstn), .ss_n_pin(ss_n_pin),
    .sclk_pin(sclk_pin), .miso_data(miso_data), .miso(miso), .touched(touched),
    .detect(detect), .transfer_permit(transfer_permit), .burst_start(burst_start),
    .settled_burst(settled_burst));
  tsh_host_model tsh_host_model_inst (.clk(clk), .transfer_permit(transfer_permit),
    .ss_n_pin(ss_n_pin), .sclk_pin(sclk_pin));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk

  task automatic complete_run;
    if (err_total == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  // Sel 0 permit driven, 1 permit high, 2 burst strobe
  task automatic wait_on(input int sel, input int lim, output int cnt);
    logic hit;
    for (cnt = 1; cnt <= lim; cnt++) begin
      @(negedge clk);
      hit = (sel == 0) ? !transfer_permit.oe_n : (sel == 1) ? transfer_permit.o : burst_start;
      if (hit === 1'b1) return;
    end
    chk("wait_bound", 1'b1, 1'b0);
    complete_run();
  endtask : wait_on

  task automatic power_up;
    rstn = 1'b0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    repeat (10) @(negedge clk);
    chk("permit_oe_n", 1'b1, transfer_permit.oe_n);
    wait_on(0, 40, n);
    chk("float_len", 1'b1, n >= 8 && n <= 14);
    chk("permit_low", 1'b0, transfer_permit.o);
    wait_on(1, 80, n);
    chk("cal_len", 1'b1, n >= 47 && n <= 54);
  endtask : power_up

  // Dummy select pulse with no sleep before it
  task automatic burst_no_sleep;
    tsh_host_model_inst.frame(0, 1'b0, ok);
    chk("host_ok", 1'b1, ok);
    if (!ok) complete_run();
    wait_on(2, 10, n);
    chk("direct_gap", 1'b1, n <= 4);
    chk("settled_burst", 1'b0, settled_burst);
    @(negedge clk);
    chk("permit_busy", 1'b0, transfer_permit.o);
  endtask : burst_no_sleep

  task automatic sleep_wake;
    miso_data = 1'b1;
    touched = 1'b1;
    tsh_host_model_inst.frame(3, 1'b1, ok);
    chk("host_ok", 1'b1, ok);
    if (!ok) complete_run();
    chk("miso_oe_n", 1'b0, miso.oe_n);
    chk("miso_o", 1'b1, miso.o);
    // Idle limit plus pin sync latency
    repeat (7) @(negedge clk);
    chk("permit_sleep", 1'b0, transfer_permit.o);
    chk("permit_sleep_oe_n", 1'b0, transfer_permit.oe_n);
    chk("miso_released", 1'b1, miso.oe_n);
    tsh_host_model_inst.release_ss();
    repeat (7) @(negedge clk);
    chk("permit_float", 1'b1, transfer_permit.oe_n);
    chk("detect_float", 1'b1, detect.oe_n);
    wait_on(2, 40, n);
    chk("settle_wait", 1'b1, n >= 12 && n <= 18);
    chk("settled_burst", 1'b1, settled_burst);
    chk("detect_oe_n", 1'b0, detect.oe_n);
    chk("detect_o", 1'b1, detect.o);
  endtask : sleep_wake

  initial begin
    miso_data = 1'b0;
    touched = 1'b0;
    err_total = 0;
    check_count = 0;
    power_up();
    burst_no_sleep();
    sleep_wake();
    complete_run();
  end
endmodule : tsh_startup_tb

`default_nettype wire
